//--- rtl/adc_ctrl_map.svh
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
// result geometry
`define RES_BITS        12
`define RES_LSB_POS     16
`define RES_MSB_POS     27
// acquisition clock counts by code
`define ACQ_CLK_0       5'h02
`define ACQ_CLK_1       5'h04
`define ACQ_CLK_2       5'h08
`define ACQ_CLK_3       5'h10
// reset values of the control inputs' meaning
`define DEF_CLK_DIV     3'h1
`define DEF_ACQ_SEL     2'h2
// clocks spent on write-back after the bit trials
`define WRITE_CLKS      4'h1
// throughput figures
`define MAX_RATE_KSPS   1000
`define REF_CLK_KHZ     41780
`define SYS_CLK_MHZ     100
`define SYS_CLK_PERIOD_NS 10
`endif

//--- rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // input configuration
  typedef enum logic [0:0] {
    MODE_SINGLE = 1'b0,
    MODE_DIFF   = 1'b1
  } in_mode_e;
  // start source selection
  typedef enum logic [2:0] {
    SRC_NONE      = 3'b000,
    SRC_SW_SINGLE = 3'b001,
    SRC_SW_CONT   = 3'b010,
    SRC_EXT_PIN   = 3'b011,
    SRC_LOGIC_ARR = 3'b100,
    SRC_FIRST_GENERAL_TIMER    = 3'b101,
    SRC_SECOND_GENERAL_TIMER    = 3'b110
  } start_src_e;
  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACQ    = 2'b01,
    ST_TRIAL  = 2'b10,
    ST_WRITE  = 2'b11
  } conv_state_e;
  // software configuration
  typedef struct packed {
    logic       enable;
    in_mode_e   mode;
    start_src_e src;
    logic [3:0] channel;
    logic       temp_sel;
    logic [2:0] clk_div;
    logic [1:0] acq_sel;
  } conv_cfg_s;
  // analog core handshake
  typedef struct packed {
    logic       sample;
    logic       trial_valid;
    logic [11:0] trial_code;
    logic [4:0] mux_sel;
    logic       diff;
  } core_ctl_s;
  // trigger inputs
  typedef struct packed {
    logic ext_conversion_start_pin;
    logic on_chip_logic_array;
    logic first_general_timer;
    logic second_general_timer;
  } trig_s;
endpackage

//--- rtl/sar_search.sv
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
// ------------------------------------------------------------
// successive approximation register
// ------------------------------------------------------------
module sar_search #(
  parameter int BITS = `RES_BITS
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            start,      // load first trial
  input  wire logic            step,       // apply comparator, move on
  input  wire logic            comp_high,  // input above trial code
  output logic [BITS-1:0]      trial,
  output logic                 last        // final bit being tried
);
  logic [BITS-1:0] trial_reg;   // current code under test
  logic [BITS-1:0] mask_reg;    // bit being tried
  logic [BITS-1:0] trial_next;
  logic [BITS-1:0] mask_next;
  wire  [BITS-1:0] kept = comp_high ? trial_reg : (trial_reg & ~mask_reg);
  wire  [BITS-1:0] msb  = {1'b1, {(BITS-1){1'b0}}};

  // next trial: keep or drop the bit, set the one below
  assign mask_next  = start ? msb : (step ? (mask_reg >> 1) : mask_reg);
  assign trial_next = start ? msb : (step ? (kept | (mask_reg >> 1)) : trial_reg);
  assign last       = mask_reg[0];
  assign trial      = trial_reg;

  // search registers
  always_ff @(posedge clk) begin
    if (reset) begin
      trial_reg <= '0;
      mask_reg  <= '0;
    end else begin
      trial_reg <= trial_next;
      mask_reg  <= mask_next;
    end
  end
endmodule

//--- rtl/adc_conversion_control.sv
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
// How it works
// - twelve-bit result from successive approximation search
// - differential or single-ended input mode selectable
// - software starts single or continuous conversions
// - pin, logic array or timer overflow trigger
// - temperature sensor is a selectable mux input
// - single-ended results are unsigned straight binary
// - up to one conversion per microsecond
// - differential result twos complement, shifted right one
// - result in bits 16..27, sign extended above in differential mode, zero above in single-ended
module adc_conversion_control #(
  parameter int CHANNELS = 16   // analog mux inputs besides temperature
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire adc_ctrl_pkg::conv_cfg_s    cfg,        // software configuration
  input  wire logic                       sw_start,   // one-cycle software go
  input  wire logic                       sw_stop,    // ends continuous mode
  input  wire adc_ctrl_pkg::trig_s        trig,       // trigger levels
  input  wire logic                       comp_high,  // comparator from core
  output adc_ctrl_pkg::core_ctl_s         core,       // drive to analog core
  output logic [31:0]                     result,     // formatted result word
  output logic                            done,       // result written pulse
  output logic                            busy        // conversion under way
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  // registers; next values are decoded below
  adc_ctrl_pkg::conv_state_e state_reg;   // sequencer state
  adc_ctrl_pkg::conv_state_e state_next;
  logic [5:0]  div_cnt_reg;               // adc clock prescaler
  logic [4:0]  acq_cnt_reg;               // acquisition clocks left
  logic        cont_reg;                  // continuous software run
  logic        trig_d_reg;                // previous trigger level
  logic [31:0] result_reg;                // stored result word
  logic        done_reg;                  // completion pulse
  // from the search block
  logic [11:0] trial;                     // trial code from search
  logic        last;                      // final bit trial

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  // prescaler terminal count per divider code
  // codes above five saturate at the slowest divide
  // returns the last count value, not the ratio
  function automatic logic [5:0] div_top(input logic [2:0] code);
    logic [5:0] n;
    n = 6'h01;
    case (code)
      3'h0:    n = 6'h01;
      3'h1:    n = 6'h02;
      3'h2:    n = 6'h04;
      3'h3:    n = 6'h08;
      3'h4:    n = 6'h10;
      default: n = 6'h20;
    endcase
    return n - 6'h01;
  endfunction

  // acquisition length per code
  // counted in adc clocks, not system cycles
  function automatic logic [4:0] acq_len(input logic [1:0] code);
    logic [4:0] n;
    n = `ACQ_CLK_0;
    case (code)
      2'h0:    n = `ACQ_CLK_0;
      2'h1:    n = `ACQ_CLK_1;
      2'h2:    n = `ACQ_CLK_2;
      default: n = `ACQ_CLK_3;
    endcase
    return n;
  endfunction

  // adc clock tick; divide by 1 ticks every cycle so 1 MSPS fits
  // fastest setting: 2 + 12 + 1 clocks, well inside one microsecond
  wire adc_tick = (div_cnt_reg == div_top(cfg.clk_div));
  // prescaler restarts on each tick and holds at zero while idle
  wire div_clear = adc_tick || (state_reg == adc_ctrl_pkg::ST_IDLE);

  // ----------------------------------------------------------
  // triggers and starts
  // ----------------------------------------------------------
  // selected trigger level
  wire trig_lvl =
    (cfg.src == adc_ctrl_pkg::SRC_EXT_PIN)   ? trig.ext_conversion_start_pin :
    (cfg.src == adc_ctrl_pkg::SRC_LOGIC_ARR) ? trig.on_chip_logic_array :
    (cfg.src == adc_ctrl_pkg::SRC_FIRST_GENERAL_TIMER)    ? trig.first_general_timer :
    (cfg.src == adc_ctrl_pkg::SRC_SECOND_GENERAL_TIMER)    ? trig.second_general_timer :
    1'b0;
  // edge detect: a held trigger level starts only one conversion
  wire trig_rise = trig_lvl & ~trig_d_reg;

  // software start for single or continuous
  wire sw_go = sw_start &
    ((cfg.src == adc_ctrl_pkg::SRC_SW_SINGLE) || (cfg.src == adc_ctrl_pkg::SRC_SW_CONT));
  // only looked at while idle; edges seen while busy are lost
  wire go = cfg.enable & (sw_go | trig_rise | cont_reg);

  // ----------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------
  // differential codes reinterpreted as signed, shifted right one
  // inverted msb makes twos complement; the shift repeats that sign
  wire [11:0] diff_code = {~trial[11], ~trial[11], trial[10:1]};
  wire [11:0] code_out  = (cfg.mode == adc_ctrl_pkg::MODE_DIFF) ? diff_code : trial;
  // top nibble copies the sign in differential mode, zero otherwise
  wire [3:0]  ext_bits  =
    (cfg.mode == adc_ctrl_pkg::MODE_DIFF) ? {4{code_out[11]}} : 4'h0;
  wire [31:0] word_next = {ext_bits, code_out, 16'h0000};

  // ----------------------------------------------------------
  // channel select
  // ----------------------------------------------------------
  // temperature is the mux input above the pin channels
  wire [4:0] mux_next = cfg.temp_sel ? 5'(CHANNELS) : {1'b0, cfg.channel};

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  // next state; every state holds unless its exit condition is met
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // wait for an accepted start
      adc_ctrl_pkg::ST_IDLE:  if (go) state_next = adc_ctrl_pkg::ST_ACQ;
      // track the input for the chosen number of adc clocks
      adc_ctrl_pkg::ST_ACQ:   if (adc_tick && acq_cnt_reg == 5'h01) begin
        state_next = adc_ctrl_pkg::ST_TRIAL;
      end
      // one bit per adc clock, msb first
      adc_ctrl_pkg::ST_TRIAL: if (adc_tick && last) state_next = adc_ctrl_pkg::ST_WRITE;
      // one write cycle, then idle, where a continuous run restarts
      adc_ctrl_pkg::ST_WRITE: state_next = adc_ctrl_pkg::ST_IDLE;
    endcase
  end

  // first trial loaded as acquisition ends
  wire sar_start = (state_reg == adc_ctrl_pkg::ST_ACQ) && (state_next == adc_ctrl_pkg::ST_TRIAL);
  // later trials advance on each adc clock of the trial phase
  wire sar_step  = (state_reg == adc_ctrl_pkg::ST_TRIAL) && adc_tick;

  // ----------------------------------------------------------
  // search
  // ----------------------------------------------------------
  // search over the sampled input
  sar_search #(.BITS(`RES_BITS)) u_sar (
    .clk       (clk),
    .reset     (reset),
    .start     (sar_start),
    .step      (sar_step),
    .comp_high (comp_high),
    .trial     (trial),
    .last      (last)
  );

  // ----------------------------------------------------------
  // storage
  // ----------------------------------------------------------
  // state and counters
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg   <= adc_ctrl_pkg::ST_IDLE;
      div_cnt_reg <= 6'h00;
      acq_cnt_reg <= 5'h00;
      trig_d_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      div_cnt_reg <= div_clear ? 6'h00 : div_cnt_reg + 6'h01;
      trig_d_reg  <= trig_lvl;
      if (state_reg == adc_ctrl_pkg::ST_IDLE) begin
        // reload while idle so a change of setting takes effect next time
        acq_cnt_reg <= acq_len(cfg.acq_sel);
      end else if (state_reg == adc_ctrl_pkg::ST_ACQ && adc_tick) begin
        // one count per adc clock
        acq_cnt_reg <= acq_cnt_reg - 5'h01;
      end
    end
  end

  // continuous run flag
  // a stop lets the conversion under way finish; its result still comes
  always_ff @(posedge clk) begin
    if (reset || sw_stop || !cfg.enable || cfg.src != adc_ctrl_pkg::SRC_SW_CONT) begin
      // stop, disable or leaving the mode ends the run
      cont_reg <= 1'b0;
    end else if (sw_start) begin
      // armed by a software go in continuous mode
      cont_reg <= 1'b1;
    end
  end

  // result write and completion pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      result_reg <= 32'h0000_0000;
      done_reg   <= 1'b0;
    end else begin
      // pulse lines up with the new word, one cycle only
      done_reg <= (state_reg == adc_ctrl_pkg::ST_WRITE);
      // word held until the next write
      if (state_reg == adc_ctrl_pkg::ST_WRITE) begin
        result_reg <= word_next;
      end
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  // controls toward the analog core; sample and trial_valid decoded from the state register, mux and mode from cfg
  assign core.sample      = (state_reg == adc_ctrl_pkg::ST_ACQ);
  assign core.trial_valid = (state_reg == adc_ctrl_pkg::ST_TRIAL);
  assign core.trial_code  = trial;
  assign core.mux_sel     = mux_next;
  assign core.diff        = (cfg.mode == adc_ctrl_pkg::MODE_DIFF);
  // registered result and pulse; status decoded from the state register
  assign result           = result_reg;
  assign done             = done_reg;
  assign busy             = (state_reg != adc_ctrl_pkg::ST_IDLE);
endmodule

//--- sim/analog_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// analog core: comparator against a per-channel input level
// ----------------------------------------------------------
module analog_core_model (
  input  wire adc_ctrl_pkg::core_ctl_s core,       // controls from the block
  input  wire logic [11:0]             level,      // base input level
  output logic                         comp_high   // comparator output
);
  logic [11:0] code;  // input code seen on the selected mux input
  // each mux input gives a distinct code, so a wrong channel shows up
  assign code = level ^ {7'h00, core.mux_sel};
  // input sits half an lsb above code; inverted lsb of trial_code outside trials
  assign comp_high = core.trial_valid ? (core.trial_code <= code) : ~core.trial_code[0];
endmodule

//--- sim/adc_conversion_control_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// port checker for the conversion controller
// ----------------------------------------------------------
module adc_conversion_control_sva #(
  parameter int CHANNELS = 16  // mux index of the temperature input
) (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire adc_ctrl_pkg::conv_cfg_s cfg,
  input wire logic                    sw_start,
  input wire adc_ctrl_pkg::core_ctl_s core,
  input wire logic [31:0]             result,
  input wire logic                    done,
  input wire logic                    busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_DONE_ONE: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  AST_LOW_ZERO: assert property (done |-> result[15:0] == 16'h0000)
    else $error("result low half not zero");
  AST_SINGLE_TOP: assert property (done && !cfg.mode |-> result[31:28] == 4'h0)
    else $error("single-ended result top bits not zero");
  AST_DIFF_SIGN: assert property (done && cfg.mode |-> result[31:26] == {6{result[27]}})
    else $error("differential result not sign extended");
  AST_MODE_PIN: assert property (core.diff == cfg.mode)
    else $error("core mode differs from configuration");
  AST_MUX_SEL: assert property (busy |->
    core.mux_sel == (cfg.temp_sel ? 5'(CHANNELS) : {1'b0, cfg.channel}))
    else $error("wrong mux input during conversion");
  AST_SW_START: assert property (sw_start && cfg.enable && !busy &&
    cfg.src inside {adc_ctrl_pkg::SRC_SW_SINGLE, adc_ctrl_pkg::SRC_SW_CONT} |=> busy)
    else $error("software start not taken");
  AST_HELD_OFF: assert property (!cfg.enable && !busy |=> !busy)
    else $error("conversion started while disabled");
  AST_TRIAL_BUSY: assert property (core.trial_valid |-> busy && !core.sample)
    else $error("bit trial outside conversion");
  AST_FAST_PATH: assert property ($rose(busy) && cfg.clk_div == 3'h0 &&
    cfg.acq_sel == 2'h0 |-> ##15 done)
    else $error("fastest conversion took wrong time");
  AST_SAMPLE_FIRST: assert property ($rose(busy) |-> core.sample && !core.trial_valid)
    else $error("conversion did not open with acquisition");
  AST_DONE_IDLE: assert property (done |-> !busy)
    else $error("done raised while still converting");
endmodule

bind adc_conversion_control adc_conversion_control_sva #(.CHANNELS(CHANNELS))
  adc_conversion_control_sva_inst (
  .clk(clk), .reset(reset), .cfg(cfg), .sw_start(sw_start), .core(core),
  .result(result), .done(done), .busy(busy));

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic                      clk = 1'b0;
  logic                      reset = 1'b1;
  adc_ctrl_pkg::conv_cfg_s   cfg;
  adc_ctrl_pkg::trig_s       trig;
  adc_ctrl_pkg::core_ctl_s   core;
  logic                      sw_start, sw_stop, comp_high, done, busy;
  logic [31:0]               result;
  logic [11:0]               level;
  int                        fail_count = 0, checked = 0, cyc = 0, t0 = 0, spare = 0;
  int                        seed = 32'h3a7d_227e;
  logic [31:0]               exp_q[$];  // expected result words
  int                        lat_q[$];  // expected latency, -1 when free
  event                      hang_ev;   // a bounded wait ran out
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  adc_conversion_control adc_conversion_control_inst (.clk(clk), .reset(reset), .cfg(cfg),
    .sw_start(sw_start), .sw_stop(sw_stop), .trig(trig), .comp_high(comp_high), .core(core),
    .result(result), .done(done), .busy(busy));
  analog_core_model analog_core_model_inst (.core(core), .level(level), .comp_high(comp_high));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // latency in cycles from the start to done
  task chk_lat(input int got, input int exp);
    chk(32'(got), 32'(exp));
  endtask
  // converter idle: no busy, no unexpected done
  task chk_idle(input logic got);
    chk({31'h0, got}, 32'h0000_0000);
  endtask
  task summarize;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // expected result word from mode and raw code
  function logic [31:0] fmt(input logic m, input logic [11:0] c);
    logic [11:0] s;
    s = {~c[11], ~c[11], c[10:1]};
    return m ? {{4{s[11]}}, s, 16'h0000} : {4'h0, c, 16'h0000};
  endfunction
  // monitor: each done takes the oldest note
  always @(negedge clk) if (done === 1'b1) begin
    if (exp_q.size() == 0) begin
      if (spare > 0) spare--;
      else chk_idle(1'b1);
    end else begin
      chk(result, exp_q.pop_front());
      if (lat_q[0] >= 0) chk_lat(cyc - t0, lat_q[0]);
      void'(lat_q.pop_front());
    end
  end
  // one start from src, n results expected, bounded wait
  task convert(input logic [2:0] src, input int lat, input int n, input int lim);
    logic [4:0] mux;
    mux = cfg.temp_sel ? 5'h10 : {1'b0, cfg.channel};
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(fmt(cfg.mode, level ^ {7'h00, mux}));
      lat_q.push_back(i == 0 ? lat : -1);
    end
    cfg.src = adc_ctrl_pkg::start_src_e'(src);
    t0 = cyc;
    if (src < 3) sw_start = 1'b1;
    else trig = adc_ctrl_pkg::trig_s'(4'b0001 << (6 - src));
    @(negedge clk);
    sw_start = 1'b0;
    for (int i = 0; i < lim && exp_q.size() > 0; i++) @(negedge clk);
    if (exp_q.size() > 0) begin
      fail_count++;
      -> hang_ev;
    end
    trig = '0;
    @(negedge clk);
  endtask
  // a wait that ran out ends the run through the closing report
  initial begin
    @(hang_ev);
    summarize();
  end
  initial begin
    cfg = '0;
    sw_start = 1'b0;
    sw_stop = 1'b0;
    trig = '0;
    level = 12'h000;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    cfg.enable = 1'b1;
    // sweep modes, acquisition lengths and divider codes 0 to 2 with random inputs
    for (int m = 0; m < 2; m++) for (int a = 0; a < 4; a++) for (int d = 0; d < 3; d++) begin
      cfg.mode = adc_ctrl_pkg::in_mode_e'(m);
      cfg.acq_sel = a[1:0];
      cfg.clk_div = d[2:0];
      cfg.channel = 4'($random(seed));
      cfg.temp_sel = 1'($random(seed));
      level = 12'($random(seed));
      convert(3'h1, (2 << a) * (1 << d) + 12 * (1 << d) + 2, 1, 300);
    end
    // divider codes above five saturate at /32
    cfg.clk_div = 3'h7;
    cfg.acq_sel = 2'h0;
    level = 12'hfff;
    convert(3'h1, 2 * 32 + 12 * 32 + 2, 1, 600);
    // every trigger source at the fastest timing
    cfg.clk_div = 3'h0;
    for (int s = 3; s < 7; s++) begin
      level = 12'($random(seed));
      convert(3'(s), 2 + 12 + 2, 1, 100);
    end
    // disabled: start ignored, monitor flags any done
    cfg.enable = 1'b0;
    cfg.src = adc_ctrl_pkg::SRC_SW_SINGLE;
    sw_start = 1'b1;
    @(negedge clk);
    sw_start = 1'b0;
    repeat (40) @(negedge clk);
    chk_idle(busy);
    // continuous run of three, then stop
    cfg.enable = 1'b1;
    convert(3'h2, -1, 3, 300);
    spare = 1;
    sw_stop = 1'b1;
    @(negedge clk);
    sw_stop = 1'b0;
    repeat (100) @(negedge clk);
    spare = 0;
    chk_idle(busy);
    summarize();
  end
endmodule
